//--- core/cpu_event_handler.sv
// Event handler: eight edge-latched event flags routed to two core event levels
//
// Summary of operation
// - Eight events, high group four, low four
// - Events never alter the program counter
// - Pending event wakes core from halt
// - Jump-on-event taken only when flag set
// - No other effect on the core
// - Groups map onto two core levels
// - Bits 7-4 high, bits 3-0 low
// - Read flags, write one clears, reset zero
// - Top event code eases software dispatch
// - Set needs enable and rising source edge
// - Top code register reads ff when empty
// - Summary bit1 high group, bit0 low
// - Sources sampled on the fastest clock
`timescale 1ns/10ps
module cpu_event_handler #(
  parameter int NUM_EVENTS = evh_pkg::NUM_EVENTS
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [NUM_EVENTS-1:0] event_src,
  output logic                       core_event_level_one,
  output logic                       core_event_level_zero,
  output logic                       irq
);
  localparam int G = evh_pkg::GROUP_SIZE;

  evh_pkg::apb_req_t       req;
  evh_pkg::apb_state_t     state_r;
  evh_pkg::apb_state_t     state_nxt;
  evh_pkg::level_summary_t summary;
  logic [NUM_EVENTS-1:0] src_r;
  logic [NUM_EVENTS-1:0] flag_r;
  logic [NUM_EVENTS-1:0] flag_nxt;
  logic [NUM_EVENTS-1:0] enable_r;
  logic [NUM_EVENTS-1:0] rise;
  logic [NUM_EVENTS-1:0] clr;
  logic [1:0]            irq_stat_r;
  logic [1:0]            irq_stat_nxt;
  logic [1:0]            irq_mask_r;
  logic [1:0]            group_rise;
  logic [7:0]            top_code;
  logic [31:0]           rdata_nxt;
  logic                  wr_ok;
  logic                  rd_ok;
  logic                  sel_flag;
  logic                  sel_en;
  logic                  sel_code;
  logic                  sel_sum;
  logic                  sel_ist;
  logic                  sel_imsk;
  logic                  mapped;

  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

  // Decode
  assign sel_flag = req.paddr == evh_pkg::OFF_FLAG;
  assign sel_en   = req.paddr == evh_pkg::OFF_ENABLE;
  assign sel_code = req.paddr == evh_pkg::OFF_TOP_CODE;
  assign sel_sum  = req.paddr == evh_pkg::OFF_SUMMARY;
  assign sel_ist  = req.paddr == evh_pkg::OFF_IRQ_STATUS;
  assign sel_imsk = req.paddr == evh_pkg::OFF_IRQ_MASK;
  assign mapped   = sel_flag | sel_en | sel_code | sel_sum | sel_ist | sel_imsk;
  // Writes land at the access edge, reads are fetched during setup
  assign wr_ok = (state_r == evh_pkg::ST_ACCESS) & req.psel & req.penable & req.pwrite &
                 mapped & pstrb[0];
  assign rd_ok = req.psel & ~req.penable & ~req.pwrite;

  always_comb begin
    state_nxt = evh_pkg::ST_IDLE;
    case (state_r)
      evh_pkg::ST_IDLE:   state_nxt = (req.psel & ~req.penable) ? evh_pkg::ST_ACCESS
                                                                 : evh_pkg::ST_IDLE;
      evh_pkg::ST_ACCESS: state_nxt = evh_pkg::ST_IDLE;
      default:            state_nxt = evh_pkg::ST_IDLE;
    endcase
  end

  // Edge detection on the system clock
  assign rise = event_src & ~src_r;
  assign clr  = (wr_ok && sel_flag) ? req.pwdata[NUM_EVENTS-1:0] : '0;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_EVENTS; gi++) begin : g_flag
      // Set beats a same-cycle clear; writing zero keeps the flag
      assign flag_nxt[gi] = (enable_r[gi] & rise[gi]) | (flag_r[gi] & ~clr[gi]);
    end
  endgenerate

  // Upper half high group, lower half low group
  assign summary.high_group_pending = |flag_r[NUM_EVENTS-1:G];
  assign summary.low_group_pending  = |flag_r[G-1:0];

  evh_prio #(
    .N(NUM_EVENTS)
  ) u_prio (
    .flags(flag_r),
    .code (top_code)
  );

  assign group_rise = {|(enable_r[NUM_EVENTS-1:G] & rise[NUM_EVENTS-1:G]),
                       |(enable_r[G-1:0] & rise[G-1:0])};
  assign irq_stat_nxt = group_rise |
                        (irq_stat_r & ~((wr_ok && sel_ist) ? req.pwdata[1:0] : 2'h0));

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (sel_flag) begin
      rdata_nxt[NUM_EVENTS-1:0] = flag_r;
    end else if (sel_en) begin
      rdata_nxt[NUM_EVENTS-1:0] = enable_r;
    end else if (sel_code) begin
      rdata_nxt[7:0] = top_code;
    end else if (sel_sum) begin
      rdata_nxt[evh_pkg::SUM_HIGH_BIT] = summary.high_group_pending;
      rdata_nxt[evh_pkg::SUM_LOW_BIT]  = summary.low_group_pending;
    end else if (sel_ist) begin
      rdata_nxt[1:0] = irq_stat_r;
    end else if (sel_imsk) begin
      rdata_nxt[1:0] = irq_mask_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r  <= evh_pkg::ST_IDLE;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      prdata   <= 32'h0000_0000;
    end else begin
      state_r  <= state_nxt;
      pready   <= req.psel & ~req.penable;
      pslverr  <= req.psel & ~req.penable & ~mapped;
      prdata   <= (rd_ok && mapped) ? rdata_nxt : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_r    <= '0;
      flag_r   <= '0;
      enable_r <= '0;
    end else begin
      src_r    <= event_src;
      flag_r   <= flag_nxt;
      if (wr_ok && sel_en) begin
        enable_r <= req.pwdata[NUM_EVENTS-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= evh_pkg::IRQ_RESET;
      irq_mask_r <= evh_pkg::IRQ_RESET;
      irq        <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      if (wr_ok && sel_imsk) begin
        irq_mask_r <= req.pwdata[1:0];
      end
      irq <= |(irq_stat_nxt & ((wr_ok && sel_imsk) ? req.pwdata[1:0] : irq_mask_r));
    end
  end

  // Levels only; no vector or jump target is produced
  // The core wakes from halt and qualifies jump-on-event on these
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_event_level_one  <= 1'b0;
      core_event_level_zero <= 1'b0;
    end else begin
      core_event_level_one  <= |flag_nxt[NUM_EVENTS-1:G];
      core_event_level_zero <= |flag_nxt[G-1:0];
    end
  end

  // Assertions
  AST_SET_ON_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
    (enable_r[0] && rise[0]) |=> flag_r[0])
    else $error("enabled edge did not set flag 0");
  AST_NO_SET_DISABLED: assert property (@(posedge pclk) disable iff (!presetn)
    (!enable_r[7] && !flag_r[7]) |=> !flag_r[7] || $past(enable_r[7]))
    else $error("disabled flag 7 set");
  AST_W1C: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ok && sel_flag && req.pwdata[3] && !(enable_r[3] && rise[3])) |=> !flag_r[3])
    else $error("write one did not clear flag 3");
  AST_W0_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ok && sel_flag && !req.pwdata[5] && flag_r[5]) |=> flag_r[5])
    else $error("write zero changed flag 5");
  AST_CODE_NONE: assert property (@(posedge pclk) disable iff (!presetn)
    (flag_r == '0) |-> (top_code == 8'hff))
    else $error("top code not ff when empty");
  AST_CODE_TOP: assert property (@(posedge pclk) disable iff (!presetn)
    flag_r[7] |-> (top_code == 8'h07))
    else $error("event 7 not ranked first");
  AST_LEVEL_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
    (|flag_r[NUM_EVENTS-1:G]) |-> core_event_level_one)
    else $error("high level dropped while flag set");
  AST_LEVEL_LOW: assert property (@(posedge pclk) disable iff (!presetn)
    core_event_level_zero |-> (|flag_r[G-1:0]))
    else $error("low level without low flag");
  AST_READY: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready)
    else $error("no ready after setup");

  // Bus side
  AST_PREADY_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
    pready
    |=> !pready)
    else $error("pready held longer than one cycle");

  AST_SLVERR_WITH_READY: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr
    |-> pready)
    else $error("pslverr without pready");

  AST_PRDATA_IDLE_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    !pready
    |-> (prdata == 32'h0000_0000))
    else $error("read data not zero outside access");

  AST_PRDATA_UPPER_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    pready
    |-> (prdata[31:NUM_EVENTS] == '0))
    else $error("upper read data not zero");

  AST_WRITE_IN_ACCESS: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ok
    |-> (req.penable && pready))
    else $error("write outside access phase");

  AST_STRB_IGNORED: assert property (@(posedge pclk) disable iff (!presetn)
    (req.psel && req.penable && req.pwrite && sel_en && !pstrb[0])
    |=> $stable(enable_r))
    else $error("write without strobe changed enables");

  AST_EN_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ok && sel_en)
    |=> (enable_r == $past(req.pwdata[NUM_EVENTS-1:0])))
    else $error("enable write lost");

  AST_MASK_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ok && sel_imsk)
    |=> (irq_mask_r == $past(req.pwdata[1:0])))
    else $error("mask write lost");

  // Event side
  AST_FLAG_CAUSE: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(flag_r[2])
    |-> $past(enable_r[2] && rise[2]))
    else $error("flag 2 set without enabled edge");

  AST_FLAG_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (flag_r[6] && !clr[6])
    |=> flag_r[6])
    else $error("flag 6 lost without clear");

  AST_SET_WINS: assert property (@(posedge pclk) disable iff (!presetn)
    (enable_r[1] && rise[1] && clr[1])
    |=> flag_r[1])
    else $error("same-cycle clear beat set of flag 1");

  AST_LEVEL_ONE_EQ: assert property (@(posedge pclk) disable iff (!presetn)
    core_event_level_one ==
    (|flag_r[NUM_EVENTS-1:G]))
    else $error("high level differs from high flags");

  AST_LEVEL_ZERO_EQ: assert property (@(posedge pclk) disable iff (!presetn)
    core_event_level_zero ==
    (|flag_r[G-1:0]))
    else $error("low level differs from low flags");

  AST_CODE_HIGHEST: assert property (@(posedge pclk) disable iff (!presetn)
    (top_code != evh_pkg::CODE_NONE)
    |-> ((flag_r >> top_code[2:0]) == NUM_EVENTS'(1)))
    else $error("top code not the highest pending flag");

  AST_CODE_NONE_EMPTY: assert property (@(posedge pclk) disable iff (!presetn)
    (top_code == evh_pkg::CODE_NONE)
    |-> (flag_r == '0))
    else $error("top code ff while a flag is set");

  AST_SUMMARY_READ: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_ok && sel_sum)
    |=> (prdata[1:0] == {$past(|flag_r[NUM_EVENTS-1:G]), $past(|flag_r[G-1:0])}))
    else $error("summary read wrong");

  AST_IRQ_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
    irq ==
    (|(irq_stat_r & irq_mask_r)))
    else $error("irq differs from masked status");

  AST_IRQ_SET: assert property (@(posedge pclk) disable iff (!presetn)
    group_rise[evh_pkg::IRQ_HIGH_BIT]
    |=> irq_stat_r[evh_pkg::IRQ_HIGH_BIT])
    else $error("high group event did not set status");

  COV_SET: cover property (@(posedge pclk) disable iff (!presetn) $rose(flag_r[4]));
  COV_CLEAR: cover property (@(posedge pclk) disable iff (!presetn) $fell(flag_r[1]));
  COV_SET_CLR: cover property (@(posedge pclk) disable iff (!presetn)
    (wr_ok && sel_flag && req.pwdata[0] && enable_r[0] && rise[0]));
  COV_IRQ: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
endmodule : cpu_event_handler

//--- core/evh_pkg.sv
// Package: offsets, field layouts, reset values and types of the event handler
package evh_pkg;
  localparam int          NUM_EVENTS     = 8;
  localparam int          GROUP_SIZE     = 4;
  localparam logic [11:0] OFF_FLAG       = 12'h000;
  localparam logic [11:0] OFF_ENABLE     = 12'h004;
  localparam logic [11:0] OFF_TOP_CODE   = 12'h008;
  localparam logic [11:0] OFF_SUMMARY    = 12'h00c;
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h010;
  localparam logic [11:0] OFF_IRQ_MASK   = 12'h014;
  localparam logic [7:0]  FLAG_RESET     = 8'h00;
  localparam logic [7:0]  ENABLE_RESET   = 8'h00;
  localparam logic [7:0]  CODE_NONE      = 8'hff;
  localparam logic [1:0]  IRQ_RESET      = 2'h0;
  localparam int          SUM_HIGH_BIT   = 1;
  localparam int          SUM_LOW_BIT    = 0;
  localparam int          IRQ_HIGH_BIT   = 1;
  localparam int          IRQ_LOW_BIT    = 0;

  typedef struct packed {
    logic       psel;
    logic       penable;
    logic       pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic high_group_pending;
    logic low_group_pending;
  } level_summary_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b01,
    ST_ACCESS = 2'b10
  } apb_state_t;
endpackage : evh_pkg

//--- core/evh_prio.sv
// Priority encoder: highest-numbered pending event, or the none code
`timescale 1ns/10ps
module evh_prio #(
  parameter int N = 8
) (
  input  wire logic [N-1:0] flags,
  output logic      [7:0]   code
);
  always_comb begin
    code = evh_pkg::CODE_NONE;
    // Upward scan so the highest index wins
    for (int i = 0; i < N; i++) begin
      if (flags[i]) begin
        code = 8'(i);
      end
    end
  end
endmodule : evh_prio

//--- tb/core_model.sv
// Core side model: halt wake-up and jump-on-event from the two event levels
`timescale 1ns/10ps
module core_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ev_one,
  input  wire logic ev_zero,
  input  wire logic halt,
  output logic      halted,
  output logic      jev_taken
);
  assign jev_taken = ev_one | ev_zero;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      halted <= 1'b0;
    else if (ev_one | ev_zero)
      halted <= 1'b0;
    else if (halt)
      halted <= 1'b1;
  end
endmodule : core_model

//--- tb/cpu_event_handler_test.sv
// Random and corner tests of the event handler over APB
`timescale 1ns/10ps
module cpu_event_handler_test;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0]  pstrb;
  logic [7:0]  src, fl, en, mk, r, w;
  logic [1:0]  st;
  logic        lv1, lv0, irq, halt, halted, jump_on_event_instruction, e;
  int          num_errors, num_checks;

  cpu_event_handler i_cpu_event_handler (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .event_src(src),
    .core_event_level_one(lv1), .core_event_level_zero(lv0), .irq(irq));
  core_model i_core_model (.pclk(pclk), .presetn(presetn), .ev_one(lv1), .ev_zero(lv0),
    .halt(halt), .halted(halted), .jev_taken(jump_on_event_instruction));

  always #12.5 pclk = ~pclk;

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      num_errors++;
      $display("ERROR %0t: got %h exp %h", $time, g, x);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      num_errors++;
      $display("ERROR %0t: no pready", $time);
    end
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
    chk(e, a > evh_pkg::OFF_IRQ_MASK);
  endtask : rd

  function automatic logic [7:0] top(input logic [7:0] f);
    logic [7:0] c;
    c = evh_pkg::CODE_NONE;
    for (int k = 0; k < 8; k++)
      if (f[k])
        c = k[7:0];
    return c;
  endfunction : top

  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out

  initial begin
    #1000000;
    num_errors++;
    close_out();
  end

  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, src, halt} = '0;
    pstrb = 4'hf;
    fl = 8'h00;
    st = 2'h0;
    void'($urandom(32'hc2360d46));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(evh_pkg::OFF_FLAG, 32'h0);
    rd(evh_pkg::OFF_TOP_CODE, 32'hff);
    rd(evh_pkg::OFF_SUMMARY, 32'h0);
    rd(12'h040, 32'h0);
    pstrb <= 4'he;
    apb(1'b1, evh_pkg::OFF_ENABLE, 32'h0000_00ff);
    pstrb <= 4'hf;
    rd(evh_pkg::OFF_ENABLE, 32'h0);
    @(posedge pclk);
    halt <= 1'b1;
    @(posedge pclk);
    halt <= 1'b0;
    @(negedge pclk);
    chk(halted, 1'b1);
    for (int i = 0; i < 40; i++) begin
      en = (i < 2) ? 8'hff : 8'($urandom);
      mk = 8'($urandom);
      r = (i == 0) ? 8'h81 : 8'($urandom);
      apb(1'b1, evh_pkg::OFF_ENABLE, {24'h0, en});
      apb(1'b1, evh_pkg::OFF_IRQ_MASK, {30'h0, mk[1:0]});
      @(posedge pclk);
      src <= r;
      @(posedge pclk);
      src <= 8'h00;
      repeat (2) @(negedge pclk);
      fl |= r & en;
      st |= {|(r[7:4] & en[7:4]), |(r[3:0] & en[3:0])};
      if (i == 0)
        chk(halted, 1'b0);
      chk(lv1, |fl[7:4]);
      chk(lv0, |fl[3:0]);
      chk(jump_on_event_instruction, |fl);
      chk(irq, |(st & mk[1:0]));
      rd(evh_pkg::OFF_FLAG, {24'h0, fl});
      rd(evh_pkg::OFF_TOP_CODE, {24'h0, top(fl)});
      rd(evh_pkg::OFF_SUMMARY, {30'h0, |fl[7:4], |fl[3:0]});
      rd(evh_pkg::OFF_ENABLE, {24'h0, en});
      rd(evh_pkg::OFF_IRQ_MASK, {30'h0, mk[1:0]});
      rd(evh_pkg::OFF_IRQ_STATUS, {30'h0, st});
      w = (i == 1) ? 8'h00 : 8'($urandom);
      apb(1'b1, evh_pkg::OFF_FLAG, {24'hffffff, w});
      fl &= ~w;
      apb(1'b1, evh_pkg::OFF_IRQ_STATUS, 32'h3);
      st = 2'h0;
      rd(evh_pkg::OFF_FLAG, {24'h0, fl});
      chk(irq, 1'b0);
    end
    // Reset in mid-run with a flag pending
    apb(1'b1, evh_pkg::OFF_ENABLE, 32'h0000_00ff);
    @(posedge pclk);
    src <= 8'h10;
    @(posedge pclk);
    src <= 8'h00;
    @(posedge pclk);
    chk(lv1, 1'b1);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(lv1, 1'b0);
    presetn <= 1'b1;
    rd(evh_pkg::OFF_FLAG, 32'h0);
    rd(evh_pkg::OFF_ENABLE, 32'h0);
    rd(evh_pkg::OFF_TOP_CODE, 32'hff);
    close_out();
  end
endmodule : cpu_event_handler_test
